// ---- rtl/timer_ctl_pkg.sv ----
package timer_ctl_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_RUN_CONTROL  = 3'h0;
   localparam logic [2:0] ADDR_SYNC_SELECT  = 3'h1;
   localparam logic [2:0] ADDR_MODE_SELECT  = 3'h2;
   localparam logic [2:0] ADDR_IRQ_STATUS_A = 3'h4;
   localparam logic [2:0] ADDR_COUNTER_CH0  = 3'h5;
   localparam logic [2:0] ADDR_COUNTER_CH1  = 3'h6;
   localparam logic [2:0] ADDR_COUNTER_CH2  = 3'h7;

   // ----------------------------------------
   // Reset values and fixed-one masks
   // ----------------------------------------
   localparam logic [7:0] RUN_RESET       = 8'hf8;
   localparam logic [7:0] SYNC_RESET      = 8'hf8;
   localparam logic [7:0] MODE_RESET      = 8'h98;
   localparam logic [7:0] STATUS_A_RESET  = 8'h88;
   localparam logic [7:0] RUN_FIXED_ONES  = 8'hf8;
   localparam logic [7:0] SYNC_FIXED_ONES = 8'hf8;
   localparam logic [7:0] MODE_FIXED_ONES = 8'h98;
   localparam logic [7:0] STAT_FIXED_ONES = 8'h88;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int QUADRATURE_SELECT_BIT   = 6;
   localparam int WRAP_FLAG_CONDITION_BIT = 5;
   localparam int MATCH_A_IRQ_ENABLE_BIT  = 6;
   localparam int CHANNELS                = 3;
   localparam int COUNT_WIDTH             = 16;
   localparam logic [15:0] COUNTER_RESET  = 16'h0000;
   localparam logic [15:0] GENERAL_RESET  = 16'hffff;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;

   typedef struct packed {
      logic [15:0] count;
      logic        up;
      logic        wrap_up;
      logic        wrap_down;
   } quad_out_type;
endpackage

// ---- rtl/quadrature_step.sv ----
`timescale 1ns/10ps
`default_nettype none
module quadrature_step
   import timer_ctl_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         phase_a_i,
   input  wire logic         phase_b_i,
   output logic              step_o,
   output logic              up_o
);
   typedef struct packed {
      logic a;
      logic b;
   } state_type;

   state_type state_r;
   state_type state_nxt;
   logic      a_edge;
   logic      b_edge;

   // ----------------------------------------
   // Edge and direction decode
   // ----------------------------------------
   always_comb begin
      state_nxt.a = phase_a_i;
      state_nxt.b = phase_b_i;
      a_edge      = phase_a_i ^ state_r.a;
      b_edge      = phase_b_i ^ state_r.b;
      step_o      = a_edge | b_edge;
      // Rise of A with B high, fall of A with B low, B edges mirrored
      if (a_edge) begin
         up_o = (phase_a_i == phase_b_i);
      end else begin
         up_o = (phase_a_i != phase_b_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/timer_common_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module timer_common_control
   import timer_ctl_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   reset_i,
   input  wire logic                   standby_i,
   input  wire timer_ctl_pkg::bus_req_type bus_i,
   output logic [7:0]                  rdata_o,
   input  wire logic [2:0]             count_tick_i,
   input  wire logic [2:0]             clear_request_i,
   input  wire logic [2:0]             capture_a_i,
   input  wire logic [2:0]             capture_mode_a_i,
   input  wire logic [47:0]            general_a_i,
   input  wire logic [47:0]            general_b_i,
   input  wire logic                   ext_clock_a_i,
   input  wire logic                   ext_clock_b_i,
   output logic [2:0]                  capcmp_pin_a_o,
   output logic [2:0]                  capcmp_pin_a_oe_o,
   output logic [2:0]                  match_a_irq_o,
   output logic                        wrap_flag_o
);
   import timer_ctl_pkg::*;

   typedef struct packed {
      logic [7:0]  run;
      logic [7:0]  sync;
      logic [7:0]  mode;
      logic [7:0]  stat_a;
      logic [2:0]  armed;
      logic [2:0]  pwm_pin;
      logic        wrap_flag;
      logic [47:0] count;
      logic [7:0]  rdata;
   } state_type;

   state_type   state_r;
   state_type   state_nxt;
   logic        quad_step;
   logic        quad_up;
   logic        quad_mode;
   logic [2:0]  match_a;
   logic [2:0]  match_b;
   logic [2:0]  advance;
   logic [2:0]  clear_ch;
   logic        sync_clear;
   logic [15:0] cur [CHANNELS];
   logic [15:0] gra [CHANNELS];
   logic [15:0] grb [CHANNELS];
   logic [15:0] nxt [CHANNELS];
   logic [2:0]  flag_set;
   logic [2:0]  flag_clr;

   // ----------------------------------------
   // Phase decoder for channel 2
   // ----------------------------------------
   quadrature_step u_quad (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .phase_a_i (ext_clock_a_i),
      .phase_b_i (ext_clock_b_i),
      .step_o    (quad_step),
      .up_o      (quad_up)
   );

   assign quad_mode = state_r.mode[QUADRATURE_SELECT_BIT];

   // ----------------------------------------
   // Per-channel compare and counting
   // ----------------------------------------
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
      assign cur[ch]     = state_r.count[ch*16 +: 16];
      assign gra[ch]     = general_a_i[ch*16 +: 16];
      assign grb[ch]     = general_b_i[ch*16 +: 16];
      assign match_a[ch] = (cur[ch] == gra[ch]);
      assign match_b[ch] = (cur[ch] == grb[ch]);
      // Quadrature replaces the tick source on channel 2
      if (ch == 2) begin : g_q
         assign advance[ch] = state_r.run[ch] &
                              (quad_mode ? quad_step : count_tick_i[ch]);
      end else begin : g_n
         assign advance[ch] = state_r.run[ch] & count_tick_i[ch];
      end
      // Lockstep channels share any lockstep member's clear
      assign clear_ch[ch] = clear_request_i[ch] |
                            (state_r.sync[ch] & sync_clear);
      // Compare match or capture sets the match A flag
      assign flag_set[ch] = capture_mode_a_i[ch] ? capture_a_i[ch]
                                                 : match_a[ch];
      // Irq follows flag and enable
      assign match_a_irq_o[ch] = state_r.stat_a[ch] &
                                 state_r.stat_a[ch + 4];
      always_comb begin
         if (clear_ch[ch]) begin
            nxt[ch] = COUNTER_RESET;
         end else if (advance[ch] && (ch != 2 || !quad_mode || quad_up)) begin
            nxt[ch] = cur[ch] + 16'h0001;
         end else if (advance[ch]) begin
            nxt[ch] = cur[ch] - 16'h0001;
         end else begin
            nxt[ch] = cur[ch];
         end
      end
   end

   assign sync_clear = |(clear_request_i & state_r.sync[2:0]);

   // Clear requires an earlier read of the flag while it was one
   assign flag_clr = (bus_i.wr && bus_i.addr == ADDR_IRQ_STATUS_A) ?
                     (state_r.armed & ~bus_i.wdata[2:0]) : 3'h0;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      state_nxt.count = {nxt[2], nxt[1], nxt[0]};
      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            ADDR_RUN_CONTROL: state_nxt.run = bus_i.wdata | RUN_FIXED_ONES;
            ADDR_SYNC_SELECT: state_nxt.sync = bus_i.wdata | SYNC_FIXED_ONES;
            ADDR_MODE_SELECT: state_nxt.mode = bus_i.wdata | MODE_FIXED_ONES;
            ADDR_IRQ_STATUS_A: begin
               state_nxt.stat_a[6:4] = bus_i.wdata[6:4];
               state_nxt.armed       = state_r.armed & bus_i.wdata[2:0];
            end
            default: state_nxt.run = state_r.run;
         endcase
      end
      // Reading a flag at one arms its clear
      if (bus_i.rd && bus_i.addr == ADDR_IRQ_STATUS_A) begin
         state_nxt.armed = state_r.armed | state_r.stat_a[2:0];
      end
      // Set beats clear
      state_nxt.stat_a[2:0] = (state_r.stat_a[2:0] & ~flag_clr) | flag_set;
      state_nxt.stat_a[7]   = 1'b1;
      state_nxt.stat_a[3]   = 1'b1;
      // Pulse pin outputs
      for (int i = 0; i < CHANNELS; i++) begin
         if (state_r.mode[i]) begin
            if (match_a[i]) begin
               state_nxt.pwm_pin[i] = 1'b1;
            end else if (match_b[i]) begin
               state_nxt.pwm_pin[i] = 1'b0;
            end
         end
      end
      // Wrap flag: overflow always, underflow unless condition bit set
      if (advance[2] && !clear_ch[2]) begin
         if (nxt[2] == COUNTER_RESET && cur[2] == GENERAL_RESET) begin
            state_nxt.wrap_flag = 1'b1;
         end else if (cur[2] == COUNTER_RESET && nxt[2] == GENERAL_RESET &&
                      !state_r.mode[WRAP_FLAG_CONDITION_BIT]) begin
            state_nxt.wrap_flag = 1'b1;
         end
      end
      // Read data, one cycle after the strobe
      state_nxt.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            ADDR_RUN_CONTROL:  state_nxt.rdata = state_r.run;
            ADDR_SYNC_SELECT:  state_nxt.rdata = state_r.sync;
            ADDR_MODE_SELECT:  state_nxt.rdata = state_r.mode;
            ADDR_IRQ_STATUS_A: state_nxt.rdata = state_r.stat_a;
            ADDR_COUNTER_CH0:  state_nxt.rdata = cur[0][7:0];
            ADDR_COUNTER_CH1:  state_nxt.rdata = cur[1][7:0];
            ADDR_COUNTER_CH2:  state_nxt.rdata = cur[2][7:0];
            default:           state_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i || standby_i) begin
         state_r.run       <= RUN_RESET;
         state_r.sync      <= SYNC_RESET;
         state_r.mode      <= MODE_RESET;
         state_r.stat_a    <= STATUS_A_RESET;
         state_r.armed     <= 3'h0;
         state_r.pwm_pin   <= 3'h0;
         state_r.wrap_flag <= 1'b0;
         state_r.count     <= '0;
         state_r.rdata     <= 8'h00;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata_o           = state_r.rdata;
   assign capcmp_pin_a_o    = state_r.pwm_pin;
   assign capcmp_pin_a_oe_o = state_r.mode[2:0];
   assign wrap_flag_o       = state_r.wrap_flag;
endmodule
`default_nettype wire

// ---- verification/timer_ctl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module timer_ctl_properties
   import timer_ctl_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       standby_i,
   input  wire timer_ctl_pkg::bus_req_type bus_i,
   input  wire logic [7:0]                 rdata_o,
   input  wire logic [2:0]                 capcmp_pin_a_oe_o,
   input  wire logic [2:0]                 match_a_irq_o,
   input  wire logic                       wrap_flag_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // --------------------------------
   // Register and output relations
   // --------------------------------
   AST_RUN_ONES: assert property (bus_i.rd && bus_i.addr == ADDR_RUN_CONTROL |=>
      rdata_o[7:3] == 5'h1f) else $error("run register upper bits not one");
   AST_SYNC_ONES: assert property (bus_i.rd && bus_i.addr == ADDR_SYNC_SELECT |=>
      rdata_o[7:3] == 5'h1f) else $error("sync register upper bits not one");
   AST_MODE_ONES: assert property (bus_i.rd && bus_i.addr == ADDR_MODE_SELECT |=>
      rdata_o[7] && rdata_o[4] && rdata_o[3]) else $error("mode fixed bits not one");
   AST_STAT_ONES: assert property (bus_i.rd && bus_i.addr == ADDR_IRQ_STATUS_A |=>
      rdata_o[7] && rdata_o[3]) else $error("status fixed bits not one");
   AST_STANDBY_INIT: assert property (standby_i ##1
      (bus_i.rd && bus_i.addr == ADDR_SYNC_SELECT) |=> rdata_o == 8'hf8)
      else $error("sync register not initialised by standby");
   AST_IRQ_OFF: assert property (bus_i.wr && bus_i.addr == ADDR_IRQ_STATUS_A &&
      bus_i.wdata[6:4] == 3'h0 |-> ##2 match_a_irq_o == 3'h0)
      else $error("irq raised with enables clear");
   AST_OE_MODE: assert property (bus_i.wr && bus_i.addr == ADDR_MODE_SELECT |->
      ##2 capcmp_pin_a_oe_o == $past(bus_i.wdata[2:0], 2))
      else $error("pin enable does not follow pulse mode bits");
   AST_WRAP_HOLD: assert property (wrap_flag_o && !standby_i |=> wrap_flag_o)
      else $error("wrap flag dropped without reset");
endmodule
bind timer_common_control timer_ctl_properties timer_ctl_properties_i (
   .clk_i(clk_i), .reset_i(reset_i), .standby_i(standby_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .capcmp_pin_a_oe_o(capcmp_pin_a_oe_o),
   .match_a_irq_o(match_a_irq_o), .wrap_flag_o(wrap_flag_o)
);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import timer_ctl_pkg::*;
   logic        clk_i, reset_i, standby_i, qa, qb, wrap;
   bus_req_type bus_i;
   logic [7:0]  rdata_o, w;
   logic [2:0]  tick, clr, cap, capm, pin, oe, irq;
   logic [47:0] gen_a, gen_b;
   int          err_total, n_tests, cyc, n;
   int          cnt [3];
   timer_common_control timer_common_control_i (.clk_i(clk_i), .reset_i(reset_i),
      .standby_i(standby_i), .bus_i(bus_i), .rdata_o(rdata_o), .count_tick_i(tick),
      .clear_request_i(clr), .capture_a_i(cap), .capture_mode_a_i(capm),
      .general_a_i(gen_a), .general_b_i(gen_b), .ext_clock_a_i(qa), .ext_clock_b_i(qb),
      .capcmp_pin_a_o(pin), .capcmp_pin_a_oe_o(oe), .match_a_irq_o(irq),
      .wrap_flag_o(wrap));
   // --------------------------------
   // Shared tasks
   // --------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus_i <= '{a, d, 1'b0, 1'b0};
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus_i <= '{a, 8'h00, 1'b0, 1'b0};
      #1 check(rdata_o, e);
      @(posedge clk_i);
   endtask
   task automatic step(input logic [2:0] t, input logic [2:0] c, input logic [2:0] k);
      tick <= t;
      clr <= c;
      cap <= k;
      @(posedge clk_i);
      tick <= 3'h0;
      clr <= 3'h0;
      cap <= 3'h0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic ph(input logic a, input logic b, input int d);
      qa <= a;
      qb <= b;
      tick <= 3'h4;
      @(posedge clk_i);
      tick <= 3'h0;
      cnt[2] = (cnt[2] + d) & 32'hffff;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 5000) begin
         err_total++;
         close_out;
      end
   end
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      {reset_i, standby_i, qa, qb, tick, clr, cap, capm} = 16'h8000;
      {gen_a, gen_b} = '1;
      bus_i = '0;
      cnt = '{0, 0, 0};
      void'($urandom(32'hb786));
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      rd(ADDR_RUN_CONTROL, 8'hf8);
      rd(ADDR_SYNC_SELECT, 8'hf8);
      rd(ADDR_MODE_SELECT, 8'h98);
      rd(ADDR_IRQ_STATUS_A, 8'h88);
      rd(3'h3, 8'h00);
      w = 8'($urandom);
      wr(ADDR_SYNC_SELECT, w);
      rd(ADDR_SYNC_SELECT, w | 8'hf8);
      wr(ADDR_RUN_CONTROL, 8'h00);
      rd(ADDR_RUN_CONTROL, 8'hf8);
      wr(ADDR_MODE_SELECT, 8'h00);
      rd(ADDR_MODE_SELECT, 8'h98);
      standby_i <= 1'b1;
      @(posedge clk_i);
      standby_i <= 1'b0;
      rd(ADDR_SYNC_SELECT, 8'hf8);
      wr(ADDR_RUN_CONTROL, 8'h05);
      n = 1 + $urandom % 8;
      repeat (n) step(3'h7, 3'h0, 3'h0);
      cnt = '{n, 0, n};
      wr(ADDR_SYNC_SELECT, 8'h03);
      wr(ADDR_RUN_CONTROL, 8'h07);
      step(3'h7, 3'h0, 3'h0);
      step(3'h0, 3'h1, 3'h0);
      cnt = '{0, 0, n + 1};
      for (int c = 0; c < 3; c++) rd(ADDR_COUNTER_CH0 + 3'(c), 8'(cnt[c]));
      wr(ADDR_IRQ_STATUS_A, 8'h47);
      rd(ADDR_IRQ_STATUS_A, 8'hc8);
      capm <= 3'h4;
      step(3'h0, 3'h0, 3'h4);
      check(irq, 3'h4);
      wr(ADDR_IRQ_STATUS_A, 8'h40);
      rd(ADDR_IRQ_STATUS_A, 8'hcc);
      wr(ADDR_IRQ_STATUS_A, 8'h40);
      rd(ADDR_IRQ_STATUS_A, 8'hc8);
      check(irq, 3'h0);
      step(3'h0, 3'h0, 3'h4);
      wr(ADDR_IRQ_STATUS_A, 8'h00);
      check(irq, 3'h0);
      gen_a[15:0] <= 16'h0002;
      gen_b[15:0] <= 16'h0005;
      wr(ADDR_MODE_SELECT, 8'h01);
      check(oe, 3'h1);
      repeat (3) step(3'h1, 3'h0, 3'h0);
      check(pin[0], 1'b1);
      repeat (3) step(3'h1, 3'h0, 3'h0);
      check(pin[0], 1'b0);
      rd(ADDR_IRQ_STATUS_A, 8'h8d);
      wr(ADDR_MODE_SELECT, 8'h40);
      step(3'h0, 3'h4, 3'h0);
      cnt[2] = 0;
      ph(1'b0, 1'b1, 1);
      ph(1'b1, 1'b1, 1);
      ph(1'b1, 1'b0, 1);
      ph(1'b0, 1'b0, 1);
      rd(ADDR_COUNTER_CH2, 8'(cnt[2]));
      check(wrap, 1'b0);
      ph(1'b1, 1'b0, -1);
      ph(1'b1, 1'b1, -1);
      ph(1'b0, 1'b1, -1);
      ph(1'b0, 1'b0, -1);
      ph(1'b1, 1'b0, -1);
      rd(ADDR_COUNTER_CH2, 8'(cnt[2]));
      check(wrap, 1'b1);
      close_out;
   end
endmodule
`default_nettype wire
